//--- upsb_pkg.sv
package upsb_pkg;
  // Port map geometry
  localparam int CH_NUM   = 4;
  localparam int CH_W     = 2;
  localparam int SEG_NUM  = 16;
  localparam int SEG_W    = 4;
  localparam int PORT_NUM = 4;
  localparam int PORT_W   = 2;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_SEGEN   = 8'h01;
  localparam logic [7:0] ADDR_STATUS  = 8'h02;
  localparam logic [7:0] ADDR_CHBASE  = 8'h10;
  localparam logic [7:0] ADDR_SEGBASE = 8'h40;

  // Control field positions
  localparam int CTRL_PWR  = 0;
  localparam int CTRL_PGS  = 1;
  localparam int CTRL_KEEP = 2;

  // Reset values
  localparam logic       RST_PWR  = 1'b1;
  localparam logic       RST_PGS  = 1'b1;
  localparam logic       RST_KEEP = 1'b0;
  localparam logic [7:0] RST_CHV  = 8'h00;
  localparam logic [3:0] RST_SEGV = 4'h0;

  typedef enum logic [1:0] {UPSB_IDLE, UPSB_SWEEP, UPSB_HOLD} upsb_state_t;
endpackage

//--- upsb_sync.sv
`timescale 1ns/100ps
module upsb_sync
  import upsb_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      stage1 <= '0;
      dout   <= '0;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

//--- upsb_user_port.sv
// How it works
// - One global power enable switches stimulus on all ports; resets on
// - Pin-group select: upper lines show channel bits 4-7 or drive ports
// - Keep setting: at sweep end bits hold, else lower lines and channel-bit upper lines return to zero; port-drive upper lines hold
//   (code: a sweep that ends while in hold stays in hold, so no lines return to zero)
// - One segment enable per channel; segments matter only when on and segmented
// - Each segment of each channel stores a four-bit value
// - Segment bit 0 drives first upper line, ascending upward
// - Reset clears all segment values; upper lines deasserted
// - With segment bits in use, upper lines show measured segment value
// - Outputs assert at segment start, update on differing segment value
// - In hold the output levels stay unchanged
// - Each channel stores an eight-bit value; resets to zero
// - Channel bit 0 drives first lower line; bits 4-7 upper lines
// - Channel bits come from the swept channel, not the edited one
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module upsb_user_port
  import upsb_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [7:0]        regRdata,
  input  wire logic              sweepActive,
  input  wire logic              sweepSegmented,
  input  wire logic              holdState,
  input  wire logic [CH_W-1:0]   sweepChannel,
  input  wire logic [SEG_W-1:0]  sweepSegment,
  input  wire logic [PORT_W-1:0] drivePort,
  output logic                   sourcePowerOn,
  output logic [3:0]             lowerLines,
  output logic [3:0]             upperLines
);
  // Sweep progress arrives from another timing domain
  localparam int SW = 3 + CH_W + SEG_W + PORT_W;

  logic [SW-1:0]       syncIn;
  logic [SW-1:0]       syncOut;
  logic                swAct;
  logic                swSeg;
  logic                swHold;
  logic [CH_W-1:0]     swCh;
  logic [SEG_W-1:0]    swSegIdx;
  logic [PORT_W-1:0]   swPort;

  assign syncIn = {sweepActive, sweepSegmented, holdState, sweepChannel, sweepSegment,
                   drivePort};

  upsb_sync #(.W(SW)) u_sync (
    .mclk (mclk),
    .srst (srst),
    .din  (syncIn),
    .dout (syncOut)
  );

  // Word taken only when two synced samples agree, so no torn index is used
  logic [SW-1:0]       syncPrev;
  logic [SW-1:0]       syncHeld;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      syncPrev <= '0;
      syncHeld <= '0;
    end
    else
    begin
      syncPrev <= syncOut;
      if (syncOut == syncPrev)
        syncHeld <= syncOut;
    end
  end

  assign {swAct, swSeg, swHold, swCh, swSegIdx, swPort} = syncHeld;

  logic                pwrEnable;
  logic                pinGroupSel;
  logic                keepAtEnd;
  logic [CH_NUM-1:0]   segEnable;
  logic [7:0]          channelBitValue [CH_NUM];
  logic [3:0]          segValue [CH_NUM][SEG_NUM];
  upsb_state_t         state;
  upsb_state_t         next_state;

  // Address decode
  logic                wrCtrl;
  logic                wrSegEn;
  logic                inChWin;
  logic                inSegWin;
  logic [CH_W-1:0]     chIdx;
  logic [CH_W-1:0]     segChIdx;
  logic [SEG_W-1:0]    segIdx;

  function automatic logic inWindow(input logic [7:0] a, input logic [7:0] base,
                                    input int cnt);
    return (a >= base) && ({24'h0, a} < {24'h0, base} + 32'(cnt));
  endfunction

  assign wrCtrl   = regWr && (regAddr == ADDR_CTRL);
  assign wrSegEn  = regWr && (regAddr == ADDR_SEGEN);
  assign inChWin  = inWindow(regAddr, ADDR_CHBASE, CH_NUM);
  assign inSegWin = inWindow(regAddr, ADDR_SEGBASE, CH_NUM * SEG_NUM);
  assign chIdx    = CH_W'(regAddr - ADDR_CHBASE);
  assign {segChIdx, segIdx} = (CH_W + SEG_W)'(regAddr - ADDR_SEGBASE);

  // Control register
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pwrEnable   <= RST_PWR;
      pinGroupSel <= RST_PGS;
      keepAtEnd   <= RST_KEEP;
      segEnable   <= '0;
    end
    else
    begin
      if (wrCtrl)
      begin
        pwrEnable   <= regWdata[CTRL_PWR];
        pinGroupSel <= regWdata[CTRL_PGS];
        keepAtEnd   <= regWdata[CTRL_KEEP];
      end
      if (wrSegEn)
        segEnable <= regWdata[CH_NUM-1:0];
    end
  end

  // Channel and segment value stores
  genvar gc;
  generate
    for (gc = 0; gc < CH_NUM; gc++)
    begin : g_ch
      always_ff @(posedge mclk)
      begin
        if (srst)
          channelBitValue[gc] <= RST_CHV;
        else if (regWr && inChWin && chIdx == CH_W'(gc))
          channelBitValue[gc] <= regWdata;
      end
      for (genvar gs = 0; gs < SEG_NUM; gs++)
      begin : g_seg
        always_ff @(posedge mclk)
        begin
          if (srst)
            segValue[gc][gs] <= RST_SEGV;
          else if (regWr && inSegWin && segChIdx == CH_W'(gc) && segIdx == SEG_W'(gs))
            segValue[gc][gs] <= regWdata[3:0];
        end
      end
    end
  endgenerate

  // Readback
  logic [7:0] rdMux;
  assign rdMux = (regAddr == ADDR_CTRL) ?
                   {5'h00, keepAtEnd, pinGroupSel, pwrEnable} :
                 (regAddr == ADDR_SEGEN) ? {{(8-CH_NUM){1'b0}}, segEnable} :
                 (regAddr == ADDR_STATUS) ?
                   {4'h0, swHold, swSeg, swAct, state == UPSB_HOLD} :
                 inChWin ? channelBitValue[chIdx] :
                 inSegWin ? {4'h0, segValue[segChIdx][segIdx]} : 8'h00;

  always_ff @(posedge mclk)
  begin
    if (srst)
      regRdata <= 8'h00;
    else if (regRd)
      regRdata <= rdMux;
    else
      regRdata <= 8'h00;
  end

  // Sweep tracking
  always_comb
  begin
    next_state = state;
    unique case (state)
      UPSB_IDLE:  if (swAct) next_state = UPSB_SWEEP;
      UPSB_SWEEP:
        if (swHold) next_state = UPSB_HOLD;
        else if (!swAct) next_state = UPSB_IDLE;
      UPSB_HOLD:  if (swAct && !swHold) next_state = UPSB_SWEEP;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      state <= UPSB_IDLE;
    else
      state <= next_state;
  end

  // Output selection
  logic [7:0] chVal;
  logic [3:0] segVal;
  logic       useSeg;
  logic [3:0] portOneHot;
  logic [3:0] upperSel;
  logic [3:0] next_lower;
  logic [3:0] next_upper;

  assign chVal      = channelBitValue[swCh];
  assign segVal     = segValue[swCh][swSegIdx];
  assign useSeg     = segEnable[swCh] && swSeg;
  assign portOneHot = 4'h1 << swPort;
  assign upperSel   = useSeg ? segVal :
                      pinGroupSel ? chVal[7:4] : portOneHot;

  always_comb
  begin
    next_lower = lowerLines;
    next_upper = upperLines;
    unique case (state)
      UPSB_SWEEP:
      begin
        // Follows segment and channel changes as they happen
        next_lower = chVal[3:0];
        next_upper = upperSel;
      end
      UPSB_HOLD:
      begin
        next_lower = lowerLines;
        next_upper = upperLines;
      end
      UPSB_IDLE:
        if (!keepAtEnd)
        begin
          next_lower = 4'h0;
          next_upper = pinGroupSel ? 4'h0 : upperLines;
        end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      lowerLines    <= 4'h0;
      upperLines    <= 4'h0;
      sourcePowerOn <= RST_PWR;
    end
    else
    begin
      lowerLines    <= next_lower;
      upperLines    <= next_upper;
      sourcePowerOn <= pwrEnable;
    end
  end

  // Checks
  property p_pwr;
    @(posedge mclk) disable iff (srst)
    $changed(pwrEnable) |=> sourcePowerOn == pwrEnable;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power enable not followed");

  property p_portsel;
    @(posedge mclk) disable iff (srst)
    (state == UPSB_SWEEP && !useSeg && !pinGroupSel) |=> $onehot(upperLines);
  endproperty
  a_portsel: assert property (p_portsel) else $error("port line not one-hot");

  property p_chgroup;
    @(posedge mclk) disable iff (srst)
    (state == UPSB_SWEEP && !useSeg && pinGroupSel) |=> upperLines == $past(chVal[7:4]);
  endproperty
  a_chgroup: assert property (p_chgroup) else $error("upper channel bits wrong");

  property p_noKeep;
    @(posedge mclk) disable iff (srst)
    (state == UPSB_IDLE && !keepAtEnd) |=> lowerLines == 4'h0;
  endproperty
  a_noKeep: assert property (p_noKeep) else $error("bits not cleared at end");

  property p_segPrio;
    @(posedge mclk) disable iff (srst)
    (state == UPSB_SWEEP && useSeg) |=> upperLines == $past(segVal);
  endproperty
  a_segPrio: assert property (p_segPrio) else $error("segment value not shown");

  sequence s_holdEnter;
    state == UPSB_HOLD;
  endsequence
  property p_hold;
    @(posedge mclk) disable iff (srst)
    s_holdEnter ##1 (state == UPSB_HOLD) |-> $stable(lowerLines) && $stable(upperLines);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved in hold");

  property p_lower;
    @(posedge mclk) disable iff (srst)
    (state == UPSB_SWEEP) |=> lowerLines == $past(chVal[3:0]);
  endproperty
  a_lower: assert property (p_lower) else $error("lower lines wrong");

  property p_rstSeg;
    @(posedge mclk) srst |=> upperLines == 4'h0 && segValue[0][0] == 4'h0;
  endproperty
  a_rstSeg: assert property (p_rstSeg) else $error("reset did not clear");

  property p_rstPwr;
    @(posedge mclk) srst |=> sourcePowerOn;
  endproperty
  a_rstPwr: assert property (p_rstPwr) else $error("power not on after reset");

  property p_portLine;
    @(posedge mclk) disable iff (srst)
    (state == UPSB_SWEEP && !useSeg && !pinGroupSel) |=> upperLines == (4'h1 << $past(swPort));
  endproperty
  a_portLine: assert property (p_portLine) else $error("wrong port line");

  property p_idleUpper;
    @(posedge mclk) disable iff (srst)
    (state == UPSB_IDLE && !keepAtEnd && pinGroupSel) |=> upperLines == 4'h0;
  endproperty
  a_idleUpper: assert property (p_idleUpper) else $error("upper bits not cleared");

  property p_keep;
    @(posedge mclk) disable iff (srst)
    (state == UPSB_IDLE && keepAtEnd) |=> $stable(lowerLines) && $stable(upperLines);
  endproperty
  a_keep: assert property (p_keep) else $error("kept bits moved");

  property p_chWrite;
    @(posedge mclk) disable iff (srst)
    (regWr && inChWin && chIdx == CH_W'(0)) |=> channelBitValue[0] == $past(regWdata);
  endproperty
  a_chWrite: assert property (p_chWrite) else $error("channel value not stored");

  property p_rdCtrl;
    @(posedge mclk) disable iff (srst)
    (regRd && regAddr == ADDR_CTRL) |=> regRdata[CTRL_PGS] == $past(pinGroupSel);
  endproperty
  a_rdCtrl: assert property (p_rdCtrl) else $error("pin group readback wrong");

  sequence s_sweepStart;
    state == UPSB_IDLE ##1 state == UPSB_SWEEP;
  endsequence
  property p_start;
    @(posedge mclk) disable iff (srst)
    s_sweepStart |=> lowerLines == $past(chVal[3:0]) && upperLines == $past(upperSel);
  endproperty
  a_start: assert property (p_start) else $error("lines not set at sweep start");
endmodule

//--- upsb_ext_equip.sv
`timescale 1ns/100ps
module upsb_ext_equip
  import upsb_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic [3:0] lowerLines,
  input  wire logic [3:0] upperLines,
  output logic      [7:0] trigCount
);
  logic [7:0] lastLines;

  // Any change of the eight lines counts as one trigger
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      lastLines <= 8'h00;
      trigCount <= 8'h00;
    end
    else
    begin
      lastLines <= {upperLines, lowerLines};
      if (lastLines != {upperLines, lowerLines})
        trigCount <= trigCount + 8'h01;
    end
  end
endmodule

//--- user_port_state_bits_test.sv
`timescale 1ns/100ps
module user_port_state_bits_test
  import upsb_pkg::*;
;
  localparam int SETTLE = 8;
  logic              mclk = 1'b0;
  logic              srst = 1'b1;
  logic [7:0]        regAddr = 8'h00;
  logic [7:0]        regWdata = 8'h00;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic [7:0]        regRdata;
  logic              sweepActive = 1'b0;
  logic              sweepSegmented = 1'b0;
  logic              holdState = 1'b0;
  logic [CH_W-1:0]   sweepChannel = '0;
  logic [SEG_W-1:0]  sweepSegment = '0;
  logic [PORT_W-1:0] drivePort = '0;
  logic              sourcePowerOn;
  logic [3:0]        lowerLines;
  logic [3:0]        upperLines;
  logic [7:0]        trigCount;
  int                n_mismatch = 0;
  int                total_checks = 0;

  always #50 mclk = ~mclk;

  upsb_user_port DUT (
    .mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sweepActive(sweepActive),
    .sweepSegmented(sweepSegmented), .holdState(holdState),
    .sweepChannel(sweepChannel), .sweepSegment(sweepSegment), .drivePort(drivePort),
    .sourcePowerOn(sourcePowerOn), .lowerLines(lowerLines), .upperLines(upperLines));

  upsb_ext_equip EQUIP (.mclk(mclk), .srst(srst), .lowerLines(lowerLines),
    .upperLines(upperLines), .trigCount(trigCount));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(what, exp, regRdata);
  endtask

  task automatic settle;
    repeat (SETTLE) @(posedge mclk);
    #1;
  endtask

  task automatic sweep(input logic a, input logic s, input logic [CH_W-1:0] c,
                       input logic [SEG_W-1:0] g, input logic [PORT_W-1:0] p,
                       input logic h);
    @(posedge mclk);
    sweepActive    <= a;
    sweepSegmented <= s;
    sweepChannel   <= c;
    sweepSegment   <= g;
    drivePort      <= p;
    holdState      <= h;
    settle;
  endtask

  task automatic lines(input logic [7:0] exp);
    chk("lines", exp, {upperLines, lowerLines});
  endtask

  task automatic t_reset;
    rchk(ADDR_CTRL, 8'h03, "ctrl");
    chk("power", 8'h01, {7'h00, sourcePowerOn});
    lines(8'h00);
    rchk(ADDR_SEGEN, 8'h00, "segen");
    rchk(ADDR_CHBASE + 8'h02, 8'h00, "chval");
    rchk(ADDR_SEGBASE + 8'h21, 8'h00, "segval");
    rchk(8'h05, 8'h00, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_power;
    wr(ADDR_CTRL, 8'h02);
    settle;
    chk("power", 8'h00, {7'h00, sourcePowerOn});
    rchk(ADDR_CTRL, 8'h02, "ctrl");
    wr(ADDR_CTRL, 8'h03);
    settle;
    chk("power", 8'h01, {7'h00, sourcePowerOn});
    $display("test power done");
  endtask

  task automatic t_chan;
    logic [7:0] t0;
    wr(ADDR_CHBASE, 8'hA5);
    wr(ADDR_CHBASE + 8'h02, 8'h3C);
    rchk(ADDR_CHBASE, 8'hA5, "chval");
    sweep(1'b1, 1'b0, 2'd0, 4'h0, 2'd0, 1'b0);
    lines(8'hA5);
    t0 = trigCount;
    sweep(1'b1, 1'b0, 2'd2, 4'h0, 2'd0, 1'b0);
    lines(8'h3C);
    chk("triggers", t0 + 8'h01, trigCount);
    $display("test channel done");
  endtask

  task automatic t_drive;
    wr(ADDR_CTRL, 8'h01);
    for (int p = 0; p < 4; p++)
    begin
      sweep(1'b1, 1'b0, 2'd2, 4'h0, p[1:0], 1'b0);
      lines({4'h1 << p, 4'hC});
    end
    $display("test drive port done");
  endtask

  task automatic t_seg;
    wr(ADDR_SEGBASE + 8'h20, 8'h01);
    wr(ADDR_SEGBASE + 8'h21, 8'h02);
    wr(ADDR_SEGBASE + 8'h2F, 8'h0F);
    sweep(1'b1, 1'b1, 2'd2, 4'h0, 2'd1, 1'b0);
    lines(8'h2C);
    wr(ADDR_SEGEN, 8'h04);
    settle;
    lines(8'h1C);
    sweep(1'b1, 1'b1, 2'd2, 4'h1, 2'd1, 1'b0);
    lines(8'h2C);
    sweep(1'b1, 1'b1, 2'd2, 4'hF, 2'd1, 1'b0);
    lines(8'hFC);
    sweep(1'b1, 1'b0, 2'd2, 4'hF, 2'd1, 1'b0);
    lines(8'h2C);
    rchk(ADDR_SEGBASE + 8'h2F, 8'h0F, "segval");
    $display("test segment done");
  endtask

  task automatic t_end;
    wr(ADDR_CTRL, 8'h03);
    sweep(1'b1, 1'b0, 2'd0, 4'h0, 2'd0, 1'b0);
    sweep(1'b0, 1'b0, 2'd0, 4'h0, 2'd0, 1'b0);
    lines(8'h00);
    wr(ADDR_CTRL, 8'h07);
    sweep(1'b1, 1'b0, 2'd0, 4'h0, 2'd0, 1'b0);
    sweep(1'b0, 1'b0, 2'd0, 4'h0, 2'd0, 1'b0);
    lines(8'hA5);
    wr(ADDR_CTRL, 8'h03);
    sweep(1'b1, 1'b0, 2'd2, 4'h0, 2'd0, 1'b0);
    sweep(1'b1, 1'b0, 2'd2, 4'h0, 2'd0, 1'b1);
    sweep(1'b0, 1'b0, 2'd0, 4'h0, 2'd0, 1'b1);
    lines(8'h3C);
    rchk(ADDR_STATUS, 8'h09, "status");
    $display("test sweep end done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    t_reset;
    t_power;
    t_chan;
    t_drive;
    t_seg;
    t_end;
    sweep(1'b0, 1'b0, 2'd0, 4'h0, 2'd0, 1'b0);
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    t_reset;
    final_report;
  end

  // Cuts a hang short
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    final_report;
  end
endmodule
